// ===== logic/tbdw_consts.vh
// Register map, field positions, reset values and counts of the time-base and watchdog block
`ifndef TBDW_CONSTS_VH
`define TBDW_CONSTS_VH

// Register word indices (byte address = index * 4)
`define TBDW_IDX_EVENT_FLAGS      3'h0
`define TBDW_IDX_INT_ENABLE       3'h1
`define TBDW_IDX_HOLD_ENABLE      3'h2
`define TBDW_IDX_SYS_CLK_CTRL     3'h3
`define TBDW_IDX_WATCHDOG_CTRL    3'h4
`define TBDW_IDX_STATUS           3'h5
`define TBDW_IDX_PORT_MODE        3'h6

// Event, interrupt and hold bit positions
`define TBDW_EV_FAST              0
`define TBDW_EV_SLOW              4

// System clock control fields
`define TBDW_SCR_FAST_SEL         0
`define TBDW_SCR_PLL_EN           1
`define TBDW_SCR_SHORT_PERIOD     3

// Watchdog control fields
`define TBDW_WDC_TIMEOUT          0
`define TBDW_WDC_PARTIAL          1
`define TBDW_WDC_SLOW_SRC         2
`define TBDW_WDC_LONG_DIV         3

// Reset values
`define TBDW_RST_NIBBLE           4'h0
`define TBDW_RST_PORT_MODE        4'hf

// Prescaler geometry and taps
`define TBDW_PRE_WIDTH            14
`define TBDW_PRE_CLR_LSB          10
`define TBDW_SHORT_TAP            12
`define TBDW_WD_SHORT_TAP         11
`define TBDW_WD_WIDTH             4

`endif

// ===== logic/tbdw_top.v
// Time-base prescalers, system clock select and watchdog with Wishbone register access
`timescale 1ns/1ps
`include "tbdw_consts.vh"

// Behaviour
// (RQ1) Two 14-bit up-counting prescalers, overflow events
// (RQ2) Fast prescaler counts main ticks, sets flag 0
// (RQ3) Flag 0 raises interrupt and hold release
// (RQ4) Fast clear resets top four stages only
// (RQ5) Slow prescaler sets flag 4, interrupt, hold
// (RQ6) Slow period 500 ms, or 125 ms
// (RQ7) Slow clear resets top four stages only
// (RQ8) Clock control bit 0 selects fast source
// (RQ9) Software enables PLL, waits, then switches
// (RQ10) Software switches back before disabling PLL
// (RQ11) Software never selects fast with PLL off
// (RQ12) Enabled 4-bit watchdog resets chip on overflow
// (RQ13) Option bit zero disables watchdog entirely
// (RQ14) Control bit 3 picks divide 2048 or 16384
// (RQ15) Control bit 2 picks fast or slow chain
// (RQ16) Clear instruction restarts the watchdog count
// (RQ17) Timeout flag set on timeout, cleared by clear
// (RQ18) Control register resets to zero, 2048 divide
// (RQ19) Partial reset loads PC, clears interrupt enables
// (RQ20) Full reset clears prescalers and watchdog source
// (RQ21) Full reset sets port modes to 1111
// (RQ22) Events synchronous, reset request one cycle
// (RQ23) Event flags stay set until cleared
module tbdw_top #(
    parameter PRE_WIDTH = `TBDW_PRE_WIDTH,
    parameter WD_WIDTH  = `TBDW_WD_WIDTH
) (
    input  wire        i_ref_clk,
    input  wire        i_rst,
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [4:0]  i_wb_adr,
    input  wire [31:0] i_wb_dat,
    input  wire [3:0]  i_wb_sel,
    output wire [31:0] o_wb_dat,
    output wire        o_wb_ack,
    input  wire        i_fast_osc_tick,
    input  wire        i_slow_osc_tick,
    input  wire        i_clear_fast_prescaler,
    input  wire        i_clear_slow_prescaler,
    input  wire        i_clear_supervision,
    input  wire        i_wd_option,
    output wire        o_fast_int_req,
    output wire        o_slow_int_req,
    output wire        o_hold_release,
    output wire        o_sys_clk_fast,
    output wire        o_pll_enable,
    output wire        o_pc_reset,
    output wire        o_full_reset,
    output wire [11:0] o_port_mode
);

    // Bus slave state
    reg  [31:0]          rd_data_reg;
    reg                  ack_reg;
    // Software-visible registers
    reg  [7:0]           event_flags_reg;
    reg  [7:0]           int_enable_reg;
    reg  [7:0]           hold_enable_reg;
    reg  [3:0]           sys_clk_ctrl_reg;
    reg  [3:0]           wd_ctrl_reg;
    reg  [11:0]          port_mode_reg;
    // Counters and the two-stage option strap synchronizer
    reg  [PRE_WIDTH-1:0] fast_pre_reg;
    reg  [PRE_WIDTH-1:0] slow_pre_reg;
    reg  [WD_WIDTH-1:0]  sup_cnt_reg;
    reg                  wd_option_meta_reg;
    reg                  wd_option_reg;
    // Registered outputs
    reg                  fast_int_reg;
    reg                  slow_int_reg;
    reg                  hold_rel_reg;
    reg                  pc_reset_reg;
    reg                  full_reset_reg;
    // Events of this cycle
    reg                  fast_ovf_reg;
    reg                  slow_ovf_reg;
    reg                  wd_tick_reg;

    wire                 bus_req;
    wire                 wr_en;
    wire [2:0]           reg_idx;
    wire                 fast_ovf;
    wire                 slow_ovf;
    wire                 fast_tap;
    wire                 slow_tap;
    wire                 wd_tick;
    wire                 wd_timeout;
    wire                 full_rst;
    wire                 part_rst;
    // Write strobes, one per writable register word
    wire                 wr_flags;
    wire                 wr_int_en;
    wire                 wr_hold_en;
    wire                 wr_clk_ctrl;
    wire                 wr_wd_ctrl;
    wire                 wr_port_mode;

    // True when every bit below a tap is one, i.e. the next tick carries into it
    function carry_at;
        input [PRE_WIDTH-1:0] cnt;
        input integer         tap;
        integer               k;
        begin
            carry_at = 1'b1;
            for (k = 0; k < PRE_WIDTH; k = k + 1) begin
                if (k < tap) begin
                    carry_at = carry_at & cnt[k];
                end
            end
        end
    endfunction

    // Word select shared by every writable register
    function wr_hit;
        input [2:0] idx;
        input [2:0] want;
        begin
            wr_hit = (idx == want);
        end
    endfunction

    // Bus decode: a new request is served once, ack drops the cycle after
    assign bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign wr_en   = bus_req & i_wb_we & i_wb_sel[0];
    assign reg_idx = i_wb_adr[4:2];

    // Status and unmapped words get no strobe, so writes there are dropped
    assign wr_flags     = wr_en & wr_hit(reg_idx, `TBDW_IDX_EVENT_FLAGS);
    assign wr_int_en    = wr_en & wr_hit(reg_idx, `TBDW_IDX_INT_ENABLE);
    assign wr_hold_en   = wr_en & wr_hit(reg_idx, `TBDW_IDX_HOLD_ENABLE);
    assign wr_clk_ctrl  = wr_en & wr_hit(reg_idx, `TBDW_IDX_SYS_CLK_CTRL);
    assign wr_wd_ctrl   = wr_en & wr_hit(reg_idx, `TBDW_IDX_WATCHDOG_CTRL);
    assign wr_port_mode = wr_en & wr_hit(reg_idx, `TBDW_IDX_PORT_MODE);

    // Overflow of the full 14-bit fast chain
    assign fast_ovf = i_fast_osc_tick & carry_at(fast_pre_reg, PRE_WIDTH); // [RQ1] [RQ2]
    // Slow chain: full overflow is 500 ms at 32768 Hz, 12-bit carry is 125 ms
    assign slow_ovf = i_slow_osc_tick &
                      (sys_clk_ctrl_reg[`TBDW_SCR_SHORT_PERIOD] ?
                       carry_at(slow_pre_reg, `TBDW_SHORT_TAP) :
                       carry_at(slow_pre_reg, PRE_WIDTH)); // [RQ5] [RQ6]

    // Watchdog clock: divide by 2048 taps bit 11 carry, by 16384 the full overflow
    assign fast_tap = wd_ctrl_reg[`TBDW_WDC_LONG_DIV] ?
                      carry_at(fast_pre_reg, PRE_WIDTH) :
                      carry_at(fast_pre_reg, `TBDW_WD_SHORT_TAP); // [RQ14]
    assign slow_tap = wd_ctrl_reg[`TBDW_WDC_LONG_DIV] ?
                      carry_at(slow_pre_reg, PRE_WIDTH) :
                      carry_at(slow_pre_reg, `TBDW_WD_SHORT_TAP); // [RQ14]
    assign wd_tick  = wd_ctrl_reg[`TBDW_WDC_SLOW_SRC] ?
                      (i_slow_osc_tick & slow_tap) :
                      (i_fast_osc_tick & fast_tap); // [RQ15]

    // Timeout only while the option enables the watchdog
    // A clear in the final tick's cycle wins, so no reset fires
    assign wd_timeout = wd_option_reg & wd_tick_reg & (&sup_cnt_reg) &
                        ~i_clear_supervision; // [RQ12] [RQ13]
    assign full_rst   = wd_timeout & ~wd_ctrl_reg[`TBDW_WDC_PARTIAL]; // [RQ19]
    assign part_rst   = wd_timeout & wd_ctrl_reg[`TBDW_WDC_PARTIAL]; // [RQ19]

    // Option strap comes from a pin: two stages before any logic reads it
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            wd_option_meta_reg <= 1'b0;
            wd_option_reg      <= 1'b0;
        end else begin
            wd_option_meta_reg <= i_wd_option;
            wd_option_reg      <= wd_option_meta_reg;
        end
    end

    // Register the raw events so everything downstream sees one-cycle pulses
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            fast_ovf_reg <= 1'b0;
            slow_ovf_reg <= 1'b0;
            wd_tick_reg  <= 1'b0;
        end else begin
            fast_ovf_reg <= fast_ovf; // [RQ22]
            slow_ovf_reg <= slow_ovf; // [RQ22]
            wd_tick_reg  <= wd_tick & wd_option_reg; // [RQ22]
        end
    end

    // Fast prescaler: only the top four stages obey the clear instruction
    // Lower stages keep counting so the base rate does not slip
    always @(posedge i_ref_clk) begin
        if (i_rst || full_rst) begin
            fast_pre_reg <= {PRE_WIDTH{1'b0}}; // [RQ20]
        end else if (i_clear_fast_prescaler) begin
            fast_pre_reg[PRE_WIDTH-1:`TBDW_PRE_CLR_LSB] <= {(PRE_WIDTH-`TBDW_PRE_CLR_LSB){1'b0}}; // [RQ4]
            if (i_fast_osc_tick) begin
                fast_pre_reg[`TBDW_PRE_CLR_LSB-1:0] <=
                    fast_pre_reg[`TBDW_PRE_CLR_LSB-1:0] + 10'h001;
            end
        end else if (i_fast_osc_tick) begin
            fast_pre_reg <= fast_pre_reg + {{(PRE_WIDTH-1){1'b0}}, 1'b1}; // [RQ1] [RQ2]
        end
    end

    // Slow prescaler: lower stages keep running through a clear
    // Same shape as the fast chain, fed by the slow tick
    always @(posedge i_ref_clk) begin
        if (i_rst || full_rst) begin
            slow_pre_reg <= {PRE_WIDTH{1'b0}}; // [RQ20]
        end else if (i_clear_slow_prescaler) begin
            slow_pre_reg[PRE_WIDTH-1:`TBDW_PRE_CLR_LSB] <= {(PRE_WIDTH-`TBDW_PRE_CLR_LSB){1'b0}}; // [RQ7]
            if (i_slow_osc_tick) begin
                slow_pre_reg[`TBDW_PRE_CLR_LSB-1:0] <=
                    slow_pre_reg[`TBDW_PRE_CLR_LSB-1:0] + 10'h001;
            end
        end else if (i_slow_osc_tick) begin
            slow_pre_reg <= slow_pre_reg + {{(PRE_WIDTH-1){1'b0}}, 1'b1}; // [RQ5]
        end
    end

    // Watchdog counter; held at zero while disabled so enabling starts clean
    always @(posedge i_ref_clk) begin
        if (i_rst || !wd_option_reg) begin
            sup_cnt_reg <= {WD_WIDTH{1'b0}}; // [RQ13]
        end else if (i_clear_supervision) begin
            sup_cnt_reg <= {WD_WIDTH{1'b0}}; // [RQ16]
        end else if (wd_tick_reg) begin
            sup_cnt_reg <= sup_cnt_reg + {{(WD_WIDTH-1){1'b0}}, 1'b1}; // [RQ12]
        end
    end

    // Event flags: hardware set wins over a software clear in the same cycle
    // Software writes ones to clear; zeros leave flags alone
    always @(posedge i_ref_clk) begin
        if (i_rst || full_rst) begin
            event_flags_reg <= 8'h00;
        end else begin
            if (wr_flags) begin
                event_flags_reg <= event_flags_reg & ~i_wb_dat[7:0];
            end
            if (fast_ovf_reg) begin
                event_flags_reg[`TBDW_EV_FAST] <= 1'b1; // [RQ2] [RQ23]
            end
            if (slow_ovf_reg) begin
                event_flags_reg[`TBDW_EV_SLOW] <= 1'b1; // [RQ5] [RQ23]
            end
        end
    end

    // Enables; either watchdog reset clears the interrupt enables
    always @(posedge i_ref_clk) begin
        if (i_rst || wd_timeout) begin
            int_enable_reg <= 8'h00; // [RQ19]
        end else if (wr_int_en) begin
            int_enable_reg <= i_wb_dat[7:0];
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_rst || full_rst) begin
            hold_enable_reg <= 8'h00;
        end else if (wr_hold_en) begin
            hold_enable_reg <= i_wb_dat[7:0];
        end
    end

    // Clock control; the write sequence around the PLL is software's duty
    always @(posedge i_ref_clk) begin
        if (i_rst || full_rst) begin
            sys_clk_ctrl_reg <= `TBDW_RST_NIBBLE;
        end else if (wr_clk_ctrl) begin
            sys_clk_ctrl_reg <= i_wb_dat[3:0]; // [RQ8] [RQ9] [RQ10] [RQ11]
        end
    end

    // Watchdog control: bit 0 is hardware-owned, set on timeout, cleared by clear
    // Full reset keeps the timeout flag so software can see the cause
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            wd_ctrl_reg <= `TBDW_RST_NIBBLE; // [RQ18]
        end else begin
            if (wr_wd_ctrl) begin
                wd_ctrl_reg[3:1] <= i_wb_dat[3:1];
            end
            if (full_rst) begin
                wd_ctrl_reg[`TBDW_WDC_LONG_DIV] <= 1'b0; // [RQ20]
                wd_ctrl_reg[`TBDW_WDC_SLOW_SRC] <= 1'b0; // [RQ20]
            end
            if (wd_timeout) begin
                wd_ctrl_reg[`TBDW_WDC_TIMEOUT] <= 1'b1; // [RQ17]
            end else if (i_clear_supervision) begin
                wd_ctrl_reg[`TBDW_WDC_TIMEOUT] <= 1'b0; // [RQ17]
            end
        end
    end

    // Port modes of three bidirectional ports; all ones means input mode
    always @(posedge i_ref_clk) begin
        if (i_rst || full_rst) begin
            port_mode_reg <= {3{`TBDW_RST_PORT_MODE}}; // [RQ21]
        end else if (wr_port_mode) begin
            port_mode_reg <= i_wb_dat[11:0];
        end
    end

    // Requests toward the core: flag gated by enable, level while both hold
    // Levels, not pulses: they drop once software clears the flag
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            fast_int_reg <= 1'b0;
            slow_int_reg <= 1'b0;
            hold_rel_reg <= 1'b0;
        end else begin
            fast_int_reg <= event_flags_reg[`TBDW_EV_FAST] & int_enable_reg[`TBDW_EV_FAST]; // [RQ3]
            slow_int_reg <= event_flags_reg[`TBDW_EV_SLOW] & int_enable_reg[`TBDW_EV_SLOW]; // [RQ5]
            hold_rel_reg <= (event_flags_reg[`TBDW_EV_FAST] & hold_enable_reg[`TBDW_EV_FAST]) |
                            (event_flags_reg[`TBDW_EV_SLOW] & hold_enable_reg[`TBDW_EV_SLOW]); // [RQ3] [RQ5]
        end
    end

    // Watchdog reset requests, one cycle each
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            pc_reset_reg   <= 1'b0;
            full_reset_reg <= 1'b0;
        end else begin
            pc_reset_reg   <= wd_timeout; // [RQ19] [RQ22]
            full_reset_reg <= full_rst; // [RQ12] [RQ22]
        end
    end

    // Bus answer: one wait state, unmapped words read zero and ignore writes
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            ack_reg     <= 1'b0;
            rd_data_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) begin
                case (reg_idx)
                    `TBDW_IDX_EVENT_FLAGS:   rd_data_reg <= {24'h00_0000, event_flags_reg};
                    `TBDW_IDX_INT_ENABLE:    rd_data_reg <= {24'h00_0000, int_enable_reg};
                    `TBDW_IDX_HOLD_ENABLE:   rd_data_reg <= {24'h00_0000, hold_enable_reg};
                    `TBDW_IDX_SYS_CLK_CTRL:  rd_data_reg <= {28'h000_0000, sys_clk_ctrl_reg};
                    `TBDW_IDX_WATCHDOG_CTRL: rd_data_reg <= {28'h000_0000, wd_ctrl_reg};
                    `TBDW_IDX_STATUS:        rd_data_reg <= {4'h0, slow_pre_reg, sup_cnt_reg,
                                                             fast_pre_reg[PRE_WIDTH-1:`TBDW_PRE_CLR_LSB],
                                                             6'h00}; // [RQ12]
                    `TBDW_IDX_PORT_MODE:     rd_data_reg <= {20'h0_0000, port_mode_reg};
                    default:                 rd_data_reg <= 32'h0000_0000;
                endcase
            end else begin
                rd_data_reg <= 32'h0000_0000;
            end
        end
    end

    assign o_wb_dat       = rd_data_reg;
    assign o_wb_ack       = ack_reg;
    assign o_fast_int_req = fast_int_reg;
    assign o_slow_int_req = slow_int_reg;
    assign o_hold_release = hold_rel_reg;
    assign o_sys_clk_fast = sys_clk_ctrl_reg[`TBDW_SCR_FAST_SEL]; // [RQ8]
    assign o_pll_enable   = sys_clk_ctrl_reg[`TBDW_SCR_PLL_EN];
    assign o_pc_reset     = pc_reset_reg;
    assign o_full_reset   = full_reset_reg;
    assign o_port_mode    = port_mode_reg;

endmodule

// ===== dv/tbdw_assertions.sv
// Port-level assertions for the time-base and watchdog block
`timescale 1ns/1ps
module tbdw_checker (
    input wire        i_ref_clk,
    input wire        i_rst,
    input wire        i_wb_cyc,
    input wire        i_wb_stb,
    input wire        i_wb_we,
    input wire [31:0] o_wb_dat,
    input wire        o_wb_ack,
    input wire        i_wd_option,
    input wire        o_fast_int_req,
    input wire        o_slow_int_req,
    input wire        o_sys_clk_fast,
    input wire        o_pll_enable,
    input wire        o_pc_reset,
    input wire        o_full_reset,
    input wire [11:0] o_port_mode
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // Bus handshake: one-cycle answer, data only with ack
    property p_ack_resp; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not answered next cycle");
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_dat_idle; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

    // Reset requests are single pulses, full implies program counter load
    property p_pc_pulse; o_pc_reset |=> !o_pc_reset; endproperty
    a_pc_pulse: assert property (p_pc_pulse) else $error("reset request too long");
    property p_full_pc; o_full_reset |-> o_pc_reset; endproperty
    a_full_pc: assert property (p_full_pc) else $error("full reset without pc load");
    property p_pc_ints; o_pc_reset |-> ##2 !o_fast_int_req && !o_slow_int_req; endproperty
    a_pc_ints: assert property (p_pc_ints) else $error("interrupts kept after timeout");

    // Option low for a while means the watchdog can never fire
    property p_wd_off; !i_wd_option [*4] |-> !o_pc_reset; endproperty
    a_wd_off: assert property (p_wd_off) else $error("timeout while watchdog disabled");

    // Fast clock select only rises by a register write
    property p_clk_sel; $rose(o_sys_clk_fast) |-> $past(i_wb_cyc && i_wb_stb && i_wb_we); endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("fast clock without a write");

    // Full reset restores port modes and clock control
    property p_full_ports; o_full_reset |=> o_port_mode == 12'hfff; endproperty
    a_full_ports: assert property (p_full_ports) else $error("port modes not set");
    property p_full_clk; o_full_reset |=> !o_sys_clk_fast && !o_pll_enable; endproperty
    a_full_clk: assert property (p_full_clk) else $error("clock control not cleared");
    property p_rst_vals; $past(i_rst) |-> o_port_mode == 12'hfff && !o_pll_enable && !o_pc_reset; endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");

    // Main scenarios reached
    c_partial: cover property (o_pc_reset && !o_full_reset);
    c_full: cover property (o_full_reset);
    c_both_int: cover property (o_fast_int_req && o_slow_int_req);
    c_fast_clk: cover property ($rose(o_sys_clk_fast));
endmodule

bind tbdw_top tbdw_checker u_chk (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_dat, .o_wb_ack,
    .i_wd_option, .o_fast_int_req, .o_slow_int_req, .o_sys_clk_fast, .o_pll_enable, .o_pc_reset,
    .o_full_reset, .o_port_mode);

// ===== dv/tbdw_top_bench.sv
// Self-checking bench for the time-base, clock select and watchdog block
`timescale 1ns/1ps
module tbdw_top_bench;
    logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [4:0]  i_wb_adr = 5'h00;
    logic [31:0] i_wb_dat = 32'h0, rd;
    logic [3:0]  i_wb_sel = 4'hf;
    logic        i_fast_osc_tick = 1'b0, i_slow_osc_tick = 1'b0, i_clear_fast_prescaler = 1'b0;
    logic        i_clear_slow_prescaler = 1'b0, i_clear_supervision = 1'b0, i_wd_option = 1'b0;
    wire  [31:0] o_wb_dat;
    wire         o_wb_ack, o_fast_int_req, o_slow_int_req, o_hold_release, o_sys_clk_fast;
    wire         o_pll_enable, o_pc_reset, o_full_reset;
    wire  [11:0] o_port_mode;
    integer      errors = 0, checks_done = 0, fcnt = 0, scnt = 0, pc_cnt = 0, full_cnt = 0;
    logic [15:0] lfsr = 16'h0054;
    logic [2:0]  widx [4] = '{3'h1, 3'h2, 3'h6, 3'h4};
    logic [31:0] wmsk [4] = '{32'hff, 32'hff, 32'hfff, 32'he};
    logic [31:0] scr_seq [4] = '{32'h2, 32'h3, 32'h2, 32'h0};

    tbdw_top dut (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat,
        .o_wb_ack, .i_fast_osc_tick, .i_slow_osc_tick, .i_clear_fast_prescaler, .i_clear_slow_prescaler,
        .i_clear_supervision, .i_wd_option, .o_fast_int_req, .o_slow_int_req, .o_hold_release,
        .o_sys_clk_fast, .o_pll_enable, .o_pc_reset, .o_full_reset, .o_port_mode);

    // Clock and reset-pulse counters
    always #20 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        if (o_pc_reset === 1'b1) pc_cnt <= pc_cnt + 1;
        if (o_full_reset === 1'b1) full_cnt <= full_cnt + 1;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Status word from the model: watchdog count is zero wherever it is read
    function automatic logic [31:0] st_exp();
        logic [13:0] f;
        logic [13:0] s;
        f = fcnt[13:0];
        s = scnt[13:0];
        return {4'h0, s, 4'h0, f[13:10], 6'h0};
    endfunction

    // Ticks to the k-th watchdog tick on the fast chain at divide 2048
    function automatic integer to_wd(input integer k);
        return 2048 - fcnt % 2048 + (k - 1) * 2048;
    endfunction

    task automatic stop_test();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Classic cycle held until ack is sampled; no fixed latency assumed
    task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= {idx, 2'b00};
        i_wb_dat <= d;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        if (o_wb_ack !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t no bus answer", $time);
            stop_test();
        end
    endtask

    task automatic rdc(input logic [2:0] idx, input logic [31:0] exp, input string what);
        wb(1'b0, idx, 32'h0);
        chk(rd, exp, what);
    endtask

    // Ticks stop afterwards so status reads are exact
    task automatic run(input logic f, input logic s, input integer n);
        repeat (n) begin
            @(posedge i_ref_clk);
            i_fast_osc_tick <= f;
            i_slow_osc_tick <= s;
        end
        @(posedge i_ref_clk);
        i_fast_osc_tick <= 1'b0;
        i_slow_osc_tick <= 1'b0;
        if (f) fcnt = (fcnt + n) % 16384;
        if (s) scnt = (scnt + n) % 16384;
    endtask

    // Run, let the event ripple three edges, compare request outputs
    task automatic evt(input logic f, input logic s, input integer n, input logic [31:0] exp, input string what);
        run(f, s, n);
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk({29'h0, o_fast_int_req, o_slow_int_req, o_hold_release}, exp, what);
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge i_ref_clk);
        {i_clear_supervision, i_clear_slow_prescaler, i_clear_fast_prescaler} <= m;
        @(posedge i_ref_clk);
        {i_clear_supervision, i_clear_slow_prescaler, i_clear_fast_prescaler} <= 3'b000;
    endtask

    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 8; i++) rdc(i[2:0], (i == 6) ? 32'hfff : 32'h0, "reset value");
        // Random readback; timeout flag stays read-only
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            wb(1'b1, widx[i % 4], {16'h0, lfsr});
            rdc(widx[i % 4], {16'h0, lfsr} & wmsk[i % 4], "readback");
        end
        wb(1'b1, 3'h7, 32'hffffffff);
        wb(1'b1, 3'h5, 32'hffffffff);
        wb(1'b1, 3'h4, 32'h0);
        rdc(3'h7, 32'h0, "unmapped");
        rdc(3'h5, 32'h0, "status");
        // Safe clock switching sequence and its outputs
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 3'h3, scr_seq[i]);
            chk({30'h0, o_pll_enable, o_sys_clk_fast}, scr_seq[i], "clock select");
        end
        // Both prescalers, partial clear, overflow events at 16384
        wb(1'b1, 3'h1, 32'h11);
        wb(1'b1, 3'h2, 32'h11);
        run(1'b1, 1'b1, 3000);
        rdc(3'h5, st_exp(), "prescaler count");
        pulse(3'b011);
        fcnt = fcnt % 1024;
        scnt = scnt % 1024;
        rdc(3'h5, st_exp(), "prescaler clear");
        evt(1'b1, 1'b1, 16383 - fcnt, 32'h0, "early event");
        evt(1'b1, 1'b1, 1, 32'h7, "overflow event");
        wb(1'b1, 3'h1, 32'h0);
        rdc(3'h0, 32'h11, "flags kept");
        chk({31'h0, o_fast_int_req}, 32'h0, "masked request");
        wb(1'b1, 3'h0, 32'h11);
        rdc(3'h0, 32'h0, "flags cleared");
        // Short slow period of 4096 ticks
        wb(1'b1, 3'h3, 32'h8);
        wb(1'b1, 3'h1, 32'h10);
        evt(1'b0, 1'b1, 4095, 32'h0, "early short period");
        evt(1'b0, 1'b1, 1, 32'h3, "short period");
        // Watchdog cleared midway, then full timeout
        wb(1'b1, 3'h1, 32'h11);
        wb(1'b1, 3'h6, 32'h5a3);
        wb(1'b1, 3'h3, 32'h2);
        i_wd_option <= 1'b1;
        run(1'b1, 1'b0, to_wd(2));
        pulse(3'b100);
        evt(1'b1, 1'b0, to_wd(16) - 1, 32'h7, "requests before timeout");
        chk(pc_cnt, 32'h0, "early timeout");
        run(1'b1, 1'b0, 1);
        repeat (3) @(posedge i_ref_clk);
        chk(pc_cnt + 16 * full_cnt, 32'h11, "full timeout");
        fcnt = 0;
        scnt = 0;
        rdc(3'h4, 32'h1, "timeout flag");
        rdc(3'h1, 32'h0, "enables after full");
        rdc(3'h6, 32'hfff, "ports after full");
        chk({20'h0, o_port_mode}, 32'hfff, "port pins after full");
        rdc(3'h3, 32'h0, "clock after full");
        rdc(3'h5, st_exp(), "prescalers after full");
        pulse(3'b100);
        rdc(3'h4, 32'h0, "flag cleared");
        // Partial timeout keeps all but the interrupt enables
        wb(1'b1, 3'h4, 32'h2);
        wb(1'b1, 3'h1, 32'h11);
        wb(1'b1, 3'h6, 32'h5a3);
        wb(1'b1, 3'h3, 32'h2);
        run(1'b1, 1'b0, to_wd(16));
        repeat (3) @(posedge i_ref_clk);
        chk(pc_cnt + 16 * full_cnt, 32'h12, "partial timeout");
        rdc(3'h4, 32'h3, "partial flag");
        rdc(3'h1, 32'h0, "partial enables");
        rdc(3'h6, 32'h5a3, "partial ports");
        chk({20'h0, o_port_mode}, 32'h5a3, "partial port pins");
        rdc(3'h3, 32'h2, "partial clock");
        stop_test();
    end
endmodule
